//--- core/remote_receiver_status.sv
// remote control receiver with status, end bit count and AXI4-Lite registers
// assumes rx_in is demodulated, idle high, synchronous to mclk
//
// How it works
// - status bit 15 reads 1 when the leader interrupt was generated
// - status bit 14 reads 1 when the excess low width interrupt was generated
// - status bit 13 reads 1 when the maximum bit cycle interrupt was generated
// - status bit 12 reads 1 when the falling edge interrupt was generated
// - status bit 7 reads 1 when a leader has been detected
// - 7-bit received count; zero means leader only, 1 to 72 exact
// - 73 or more received bits give a count in the upper range
// - the count never shows a running value during reception
// - the final bit count is latched when reception completes
// - the status flags and leader bit are refreshed at every receiver interrupt, the count only at completion
// - writes to the status register are ignored
// - reception goes on past 72 bits until max cycle or low width ends it
// - data beyond 72 bits is not guaranteed; software treats it as unreliable
// - 7-bit read/write expected bit count; zero means no count set
// - values 1 to 72 select that expected reception length
// - expected count is applied together with the maximum cycle condition
// - the input is sampled at a nominal 32.768 kHz rate
`timescale 1ns/1ps
module remote_receiver_status
   import remote_rx_pkg::*;
#(
   parameter int FS_DIVIDE    = remote_rx_pkg::FS_DIV,
   parameter int LEADER_TICKS = 16,
   parameter int MAX_TICKS    = 40,
   parameter int LOW_TICKS    = 30
)
(
   input  wire logic        mclk,
   input  wire logic        reset_n,
   input  wire logic        rx_in,
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             irq
);
   import remote_rx_pkg::*;

   logic                rst_meta;
   logic                rst_n;
   logic [15:0]         fs_cnt;
   logic                fs_tick;
   logic                rx_prev;
   logic                fall;
   logic                rise;
   rx_state_t           state;
   logic [7:0]          width;
   logic [7:0]          cyc;
   logic [7:0]          low;
   logic [COUNT_W-1:0]  bits;
   logic                leader_live;
   logic [EV_W-1:0]     ev;
   logic                done;
   logic [COUNT_W-1:0]  final_count;
   logic [EV_W-1:0]     status_flags;
   logic                leader_seen;
   logic [COUNT_W-1:0]  received_bit_count;
   logic [COUNT_W-1:0]  expected_bit_count_one;
   logic [EV_W-1:0]     irq_status;
   logic [EV_W-1:0]     irq_mask;
   logic                aw_got;
   logic                w_got;
   logic [3:0]          aw_addr;
   logic [31:0]         w_data;
   logic [3:0]          w_strb;
   logic                wr_fire;
   logic [31:0]         receive_status;
   logic [31:0]         next_rdata;
   logic [1:0]          next_rresp;

   // reset release through two flip-flops
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // sampling tick divider
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fs_cnt  <= 16'h0000;
         fs_tick <= 1'b0;
      end
      else if (fs_cnt == 16'(FS_DIVIDE - 1))
      begin
         fs_cnt  <= 16'h0000;
         fs_tick <= 1'b1;
      end
      else
      begin
         fs_cnt  <= fs_cnt + 16'h0001;
         fs_tick <= 1'b0;
      end
   end

   // input edge detection
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         rx_prev <= 1'b1;
      else
         rx_prev <= rx_in;
   end

   assign fall = rx_prev & ~rx_in;
   assign rise = ~rx_prev & rx_in;

   // final count: with an expected count one above the falling edge count, the unterminated last bit
   // is counted when the max cycle ends the frame
   always_comb
   begin
      final_count = bits;
      if (ev[EV_MAX] && expected_bit_count_one != RST_COUNT
          && bits + 7'h01 == expected_bit_count_one)
         final_count = expected_bit_count_one;
   end

   // receiver state machine
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state       <= ST_IDLE;
         width       <= 8'h00;
         cyc         <= 8'h00;
         low         <= 8'h00;
         bits        <= RST_COUNT;
         leader_live <= 1'b0;
         ev          <= RST_EVENTS;
         done        <= 1'b0;
      end
      else
      begin
         ev   <= RST_EVENTS;
         done <= 1'b0;
         case (state)
            ST_IDLE:
            begin
               width <= 8'h00;
               if (fall)
                  state <= ST_LEAD;
            end
            ST_LEAD:
            begin
               if (fs_tick && width != 8'hFF)
                  width <= width + 8'h01;
               if (rise)
               begin
                  if (width >= 8'(LEADER_TICKS))
                  begin
                     state           <= ST_DATA;
                     ev[EV_LEADER]   <= 1'b1;
                     leader_live     <= 1'b1;
                     bits            <= RST_COUNT;
                     cyc             <= 8'h00;
                     low             <= 8'h00;
                  end
                  else
                     state <= ST_IDLE;
               end
            end
            ST_DATA:
            begin
               if (fs_tick)
               begin
                  cyc <= (cyc == 8'hFF) ? cyc : cyc + 8'h01;
                  low <= rx_in ? 8'h00 : ((low == 8'hFF) ? low : low + 8'h01);
               end
               if (fall)
               begin
                  ev[EV_EDGE] <= 1'b1;
                  cyc         <= 8'h00;
                  if (bits != COUNT_SAT)
                     bits <= bits + 7'h01;
               end
               if (!rx_in && low >= 8'(LOW_TICKS))
               begin
                  ev[EV_LOW]  <= 1'b1;
                  done        <= 1'b1;
                  state       <= ST_IDLE;
               end
               else if (cyc >= 8'(MAX_TICKS))
               begin
                  ev[EV_MAX]  <= 1'b1;
                  done        <= 1'b1;
                  state       <= ST_IDLE;
               end
            end
            default:
               state <= ST_IDLE;
         endcase
         if (done)
            leader_live <= 1'b0;
      end
   end

   // status snapshot at each interrupt, count only at completion
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         status_flags       <= RST_EVENTS;
         leader_seen        <= 1'b0;
         received_bit_count <= RST_COUNT;
      end
      else if (ev != RST_EVENTS)
      begin
         status_flags <= ev;
         leader_seen  <= leader_live | ev[EV_LEADER];
         if (ev[EV_LOW] || ev[EV_MAX])
            received_bit_count <= final_count;
      end
   end

   assign receive_status = {16'h0000,
                            status_flags[EV_LEADER],
                            status_flags[EV_LOW],
                            status_flags[EV_MAX],
                            status_flags[EV_EDGE],
                            4'h0,
                            leader_seen,
                            received_bit_count};

   // write channel acceptance, either order
   assign wr_fire = aw_got & w_got & ~s_axi_bvalid;

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         aw_got        <= 1'b0;
         w_got         <= 1'b0;
         aw_addr       <= 4'h0;
         w_data        <= 32'h0000_0000;
         w_strb        <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_got        <= 1'b1;
            aw_addr       <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_got        <= 1'b1;
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire)
         begin
            aw_got       <= 1'b0;
            w_got        <= 1'b0;
            s_axi_bvalid <= 1'b1;
            case (aw_addr)
               OFF_RECEIVE_STATUS, OFF_EXPECTED_ONE, OFF_IRQ_STATUS, OFF_IRQ_MASK:
                  s_axi_bresp <= RESP_OKAY;
               default:
                  s_axi_bresp <= RESP_SLVERR;
            endcase
         end
         if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // expected receive bit count register
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         expected_bit_count_one <= RST_COUNT;
      else if (wr_fire && aw_addr == OFF_EXPECTED_ONE && w_strb[0])
         expected_bit_count_one <= w_data[COUNT_W-1:0];
   end

   // interrupt status, write one to clear, a new event wins
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         irq_status <= RST_EVENTS;
      else if (wr_fire && aw_addr == OFF_IRQ_STATUS && w_strb[0])
         irq_status <= (irq_status & ~w_data[EV_W-1:0]) | ev;
      else
         irq_status <= irq_status | ev;
   end

   // interrupt mask
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         irq_mask <= RST_EVENTS;
      else if (wr_fire && aw_addr == OFF_IRQ_MASK && w_strb[0])
         irq_mask <= w_data[EV_W-1:0];
   end

   // interrupt output
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         irq <= 1'b0;
      else
         irq <= |(irq_status & irq_mask);
   end

   // read data select
   always_comb
   begin
      next_rresp = RESP_OKAY;
      case (s_axi_araddr)
         OFF_RECEIVE_STATUS: next_rdata = receive_status;
         OFF_EXPECTED_ONE:   next_rdata = {25'h0000000, expected_bit_count_one};
         OFF_IRQ_STATUS:     next_rdata = {28'h0000000, irq_status};
         OFF_IRQ_MASK:       next_rdata = {28'h0000000, irq_mask};
         default:
         begin
            next_rdata = 32'h0000_0000;
            next_rresp = RESP_SLVERR;
         end
      endcase
   end

   // read channel, answer one cycle after the address
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= next_rdata;
         s_axi_rresp   <= next_rresp;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

endmodule

//--- core/remote_rx_pkg.sv
// package for the remote control receiver status block
// assumes a 32-bit AXI4-Lite register bus and a 200 MHz mclk
package remote_rx_pkg;

   // register byte offsets
   localparam logic [3:0] OFF_RECEIVE_STATUS   = 4'h0;
   localparam logic [3:0] OFF_EXPECTED_ONE     = 4'h4;
   localparam logic [3:0] OFF_IRQ_STATUS       = 4'h8;
   localparam logic [3:0] OFF_IRQ_MASK         = 4'hC;

   // receive_status field positions
   localparam int POS_LEADER_IRQ       = 15;
   localparam int POS_LOW_WIDTH_IRQ    = 14;
   localparam int POS_MAX_CYCLE_IRQ    = 13;
   localparam int POS_FALLING_EDGE_IRQ = 12;
   localparam int POS_LEADER_SEEN      = 7;
   localparam int POS_BIT_COUNT        = 0;
   localparam int COUNT_W              = 7;

   // event vector order, also the irq_status / irq_mask layout
   localparam int EV_EDGE   = 0;
   localparam int EV_MAX    = 1;
   localparam int EV_LOW    = 2;
   localparam int EV_LEADER = 3;
   localparam int EV_W      = 4;

   // reset values, count saturation value and last exact count (72)
   localparam logic [COUNT_W-1:0] RST_COUNT    = 7'h00;
   localparam logic [EV_W-1:0]    RST_EVENTS   = 4'h0;
   localparam logic [COUNT_W-1:0] COUNT_SAT    = 7'h7F;
   localparam logic [COUNT_W-1:0] COUNT_MAX_OK = 7'h48;

   // sampling clock timing
   localparam longint MCLK_HZ = 200_000_000;
   localparam longint FS_HZ   = 32_768;
   localparam int     FS_DIV  = int'(MCLK_HZ / FS_HZ);

   // bus response codes
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // receiver states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_LEAD = 3'b010,
      ST_DATA = 3'b100
   } rx_state_t;

endpackage

//--- dv/remote_rx_monitor.sv
// checker for the receiver register bus and status reads
// bound to remote_receiver_status, sees only its ports
`timescale 1ns/1ps
module remote_rx_monitor
   import remote_rx_pkg::*;
(
   input wire logic        mclk,
   input wire logic        reset_n,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [3:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        irq
);
   logic [3:0] raddr;
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   // address of the read under way
   always_ff @(posedge mclk or negedge reset_n)
      if (!reset_n)
         raddr <= 4'h0;
      else if (s_axi_arvalid && s_axi_arready)
         raddr <= s_axi_araddr;
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");
   property p_r_answer;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_r_answer: assert property (p_r_answer) else $error("read answer late");
   property p_b_answer;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
   endproperty
   a_b_answer: assert property (p_b_answer) else $error("write answer late");
   property p_busy;
      s_axi_rvalid || s_axi_bvalid |-> !s_axi_arready || !s_axi_awready;
   endproperty
   a_busy: assert property (p_busy) else $error("request taken while busy");
   property p_stat_zero;
      s_axi_rvalid && raddr == OFF_RECEIVE_STATUS |-> s_axi_rdata[31:16] == 16'h0
         && s_axi_rdata[11:8] == 4'h0;
   endproperty
   a_stat_zero: assert property (p_stat_zero) else $error("status unused bits set");
   property p_one_flag;
      s_axi_rvalid && raddr == OFF_RECEIVE_STATUS |-> $onehot0(s_axi_rdata[15:12]);
   endproperty
   a_one_flag: assert property (p_one_flag) else $error("stale status flags");
   property p_exp_width;
      s_axi_rvalid && raddr == OFF_EXPECTED_ONE |-> s_axi_rdata[31:7] == 25'h0;
   endproperty
   a_exp_width: assert property (p_exp_width) else $error("expected count too wide");
   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_status: cover property (s_axi_rvalid && raddr == OFF_RECEIVE_STATUS);
   c_irq: cover property ($rose(irq));
endmodule
bind remote_receiver_status remote_rx_monitor mon (.mclk, .reset_n, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
   .irq);

//--- dv/remote_rx_source.sv
// behavioural remote control source on rx_in, idle high
// assumes a sampling tick every 4 mclk: leader 20 ticks, bit 4 ticks
`timescale 1ns/1ps
module remote_rx_source
(
   input  wire logic mclk,
   output logic      rx
);
   initial rx = 1'b1;
   // leader, one falling edge a bit, then max cycle or low width end
   task automatic send_frame(input int nbits, input bit low_end);
      @(posedge mclk) rx <= 1'b0;
      repeat (80) @(posedge mclk);
      for (int i = 0; i < nbits; i++)
      begin
         rx <= 1'b1;
         repeat (8) @(posedge mclk);
         rx <= 1'b0;
         repeat (8) @(posedge mclk);
      end
      rx <= 1'b1;
      repeat (8) @(posedge mclk);
      rx <= !low_end;
      repeat (200) @(posedge mclk);
      rx <= 1'b1;
      repeat (10) @(posedge mclk);
   endtask
endmodule

//--- dv/remote_rx_status_endcount_tb.sv
// self-checking bench for remote_receiver_status
// drives AXI4-Lite at mclk rising edges; rx_in comes from remote_rx_source
`timescale 1ns/1ps
module remote_rx_status_endcount_tb;
   import remote_rx_pkg::*;
   logic        mclk = 1'b0, reset_n = 1'b0, rx_in, irq;
   logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
   logic [31:0] wdata = 32'h0, rdata, d, v;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, r;
   int          num_errors = 0, num_checks = 0, cnt;
   int          fn[5] = '{0, 0, 80, 3, 4}, fl[5] = '{0, 0, 0, 1, 0}, fx[5] = '{0, 0, 0, 0, 5};
   always #2.5 mclk = ~mclk;
   remote_rx_source src (.mclk(mclk), .rx(rx_in));
   remote_receiver_status #(.FS_DIVIDE(4)) dut (.mclk(mclk), .reset_n(reset_n), .rx_in(rx_in),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .irq(irq));
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // one write: address and data offered together, held until taken
   task automatic wr(input logic [3:0] a, input logic [31:0] dat, output logic [1:0] resp);
      int n;
      n = 0;
      @(posedge mclk);
      awaddr <= a;
      wdata <= dat;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge mclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         n++;
      end while (bvalid !== 1'b1 && n < 100);
      resp = bresp;
      bready <= 1'b0;
      check("write answer", 32'(n < 100), 32'h1);
   endtask
   // one read, data taken at the edge that shows rvalid
   task automatic rd(input logic [3:0] a, output logic [31:0] dat, output logic [1:0] resp);
      int n;
      n = 0;
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge mclk);
         if (arready === 1'b1) arvalid <= 1'b0;
         n++;
      end while (rvalid !== 1'b1 && n < 100);
      dat = rdata;
      resp = rresp;
      rready <= 1'b0;
      check("read answer", 32'(n < 100), 32'h1);
   endtask
   initial
   begin
      #200_000;
      num_errors++;
      end_sim();
   end
   initial
   begin
      void'($urandom(48));
      repeat (12) @(posedge mclk);
      reset_n <= 1'b1;
      repeat (3) @(posedge mclk);
      for (int i = 0; i < 4; i++)
      begin
         rd(4'(i * 4), d, r);
         check("reset value", d, 32'h0);
      end
      v = $urandom;
      v[6:0] = 7'($urandom_range(0, 72));
      wr(OFF_EXPECTED_ONE, v, r);
      rd(OFF_EXPECTED_ONE, d, r);
      check("expected count", d, {25'h0, v[6:0]});
      wr(4'h2, 32'h1, r);
      check("unmapped write", 32'(r), 32'(RESP_SLVERR));
      rd(4'h2, d, r);
      check("unmapped read", d | 32'(r), 32'(RESP_SLVERR));
      fn[1] = $urandom_range(1, 20);
      for (int i = 0; i < 5; i++)
      begin
         wr(OFF_EXPECTED_ONE, 32'(fx[i]), r);
         src.send_frame(fn[i], fl[i][0]);
         cnt = (fx[i] != 0 && fn[i] == fx[i] - 1) ? fx[i] : fn[i];
         rd(OFF_RECEIVE_STATUS, d, r);
         if (fl[i] != 0)
            check("low end status", d & 32'hFFFFFF80, 32'h4080);
         else
            check("max end status", d, 32'h2080 | 32'(cnt));
      end
      // reads at fixed points of the frame: after the leader, then between bits
      fork
         src.send_frame(6, 1'b0);
         begin
            repeat (85) @(posedge mclk);
            rd(OFF_RECEIVE_STATUS, d, r);
            check("leader status", d, 32'h8085);
            repeat (62) @(posedge mclk);
            rd(OFF_RECEIVE_STATUS, d, r);
            check("mid-frame status", d, 32'h1085);
         end
      join
      wr(OFF_RECEIVE_STATUS, 32'h0, r);
      check("status write resp", 32'(r), 32'(RESP_OKAY));
      rd(OFF_RECEIVE_STATUS, d, r);
      check("status after write", d, 32'h2086);
      wr(OFF_IRQ_STATUS, 32'hF, r);
      src.send_frame(2, 1'b0);
      rd(OFF_IRQ_STATUS, d, r);
      check("irq status", d, 32'hB);
      check("irq masked", 32'(irq), 32'h0);
      wr(OFF_IRQ_MASK, 32'h2, r);
      repeat (2) @(posedge mclk);
      check("irq raised", 32'(irq), 32'h1);
      wr(OFF_IRQ_STATUS, 32'h2, r);
      repeat (2) @(posedge mclk);
      check("irq cleared", 32'(irq), 32'h0);
      rd(OFF_IRQ_STATUS, d, r);
      check("irq status cleared", d, 32'h9);
      // second reset in mid-run: every register returns to zero
      reset_n <= 1'b0;
      repeat (4) @(posedge mclk);
      reset_n <= 1'b1;
      repeat (3) @(posedge mclk);
      for (int i = 0; i < 4; i++)
      begin
         rd(4'(i * 4), d, r);
         check("mid-run reset value", d, 32'h0);
      end
      end_sim();
   end
endmodule
